/* rtl/sbcr_pkg.sv */
`default_nettype none
package sbcr_pkg;
  // ==========================================================
  // Array geometry
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 16;
  localparam int PAR_W   = 2;
  localparam int LANES   = 2;
  localparam int LANE_D  = 8;
  localparam int LANE_W  = 9;
  localparam int WORD_W  = 18;
  localparam int DEPTH   = 131072;
  localparam int CNT_W   = 2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SLEEP_CYCLES   = 2;
  localparam logic [1:0] SLEEP_LAST = 2'(SLEEP_CYCLES - 1);

  // ==========================================================
  // APB register map
  localparam int PADDR_W = 8;
  localparam int PDATA_W = 32;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0c;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam logic CTRL_SLEEP_RST = 1'b0;
  localparam int ST_SLEEP_LSB  = 0;
  localparam int ST_ACTIVE_BIT = 2;
  localparam int ST_RDV_BIT    = 3;
  localparam int ST_CNT_LSB    = 4;
  localparam int ST_ORDER_BIT  = 6;
  localparam int EV_CNT_W      = 16;

  // ==========================================================
  // Sleep sequencer states
  typedef enum logic [1:0] {
    SBCR_AWAKE = 2'b00,
    SBCR_ENTER = 2'b01,
    SBCR_SLEEP = 2'b10,
    SBCR_EXIT  = 2'b11
  } sbcr_sleep_t;

  // ==========================================================
  // Helpers
  function automatic logic [1:0] burst_addr(input logic [1:0] start,
                                            input logic [1:0] idx,
                                            input logic       inter);
    burst_addr = inter ? (start ^ idx) : 2'(start + idx);
  endfunction

  function automatic logic [1:0] write_lanes(input logic       gw_n,
                                             input logic       bwe_n,
                                             input logic [1:0] bs_n);
    if (!gw_n) begin
      write_lanes = 2'b11;
    end else if (!bwe_n) begin
      write_lanes = ~bs_n;
    end else begin
      write_lanes = 2'b00;
    end
  endfunction
endpackage
`default_nettype wire

/* rtl/sbcr_mem.sv */
`default_nettype none
module sbcr_mem (
  // Clock
  input  wire logic                        clk,
  // Write port
  input  wire logic                        we,
  input  wire logic [sbcr_pkg::LANES-1:0]  lane_en,
  input  wire logic [sbcr_pkg::ADDR_W-1:0] addr,
  input  wire logic [sbcr_pkg::WORD_W-1:0] wdata,
  // Read port
  output logic      [sbcr_pkg::WORD_W-1:0] rdata
);
  logic [sbcr_pkg::WORD_W-1:0] mem_r [0:sbcr_pkg::DEPTH-1];

  // ==========================================================
  // Lane-masked write, registered read; contents never reset
  always_ff @(posedge clk) begin
    if (we) begin
      for (int i = 0; i < sbcr_pkg::LANES; i++) begin
        if (lane_en[i]) begin
          mem_r[addr][i*sbcr_pkg::LANE_W +: sbcr_pkg::LANE_W] <=
            wdata[i*sbcr_pkg::LANE_W +: sbcr_pkg::LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem_r[addr];
  end
endmodule
`default_nettype wire

/* rtl/sbcr_burst.sv */
`default_nettype none
module sbcr_burst (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       load,
  input  wire logic [1:0] load_val,
  input  wire logic       step,
  input  wire logic       inter,
  // Low address bits
  output logic      [1:0] cur,
  output logic      [1:0] nxt
);
  logic [1:0] start_r;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;

  assign idx_nxt = 2'(idx_r + 2'h1);
  assign cur     = sbcr_pkg::burst_addr(start_r, idx_r, inter);
  assign nxt     = sbcr_pkg::burst_addr(start_r, idx_nxt, inter);

  // ==========================================================
  // Start value and wrapping step index
  always_ff @(posedge clk) begin
    if (reset) begin
      start_r <= 2'h0;
      idx_r   <= 2'h0;
    end else if (load) begin
      start_r <= load_val;
      idx_r   <= 2'h0;
    end else if (step) begin
      idx_r   <= idx_nxt;
    end
  end
endmodule
`default_nettype wire

/* rtl/sbcr_top.sv */
// What this block does
// R1: Array is 128K words of 18 bits: 16 data plus 2 parity, shared lines.
// R2: All enables active and processor strobe low load address and start access.
// R3: Processor-strobe access ignores write inputs first cycle; writes on next edge.
// R4: Byte select 0 gates data 7:0 and parity 0; select 1 gates 15:8, parity 1.
// R5: Any detected write releases data and parity lines regardless of output enable.
// R6: Outside party drops output enable before presenting write data.
// R7: Controller strobe alone with write inputs active writes data at captured address.
// R8: Both strobes asserted together: only the processor strobe counts.
// R9: Enables active and either strobe low start a read at latched address.
// R10: Outside party keeps write inputs inactive on a controller-strobe read start.
// R11: Read data drive the lines only while output enable is low.
// R12: Two-bit wrapping burst counter loaded from two low address bits.
// R13: Order select low means linear, high means interleaved.
// R14: Unconnected order select behaves as high, interleaved.
// R15: Interleaved order XORs start with 01, 10, 11.
// R16: Linear order adds one modulo four each step.
// R17: Advance input decides whether the counter steps this cycle.
// R18: No strobe: advance low steps, advance high suspends the burst.
// R19: Sleep request high enters sleep; entry and exit take two cycles.
// R20: Sleep keeps contents; pending access is dropped as invalid.
// R21: Outside party deselects the device before raising sleep request.
// R22: Outside party keeps enables and strobes inactive during sleep recovery.
// R23: While sleeping the data lines stay undriven.
// R24: Burst replaces only the two low address bits; upper bits held.
//
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
module sbcr_top (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  // APB slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [sbcr_pkg::PADDR_W-1:0]  PADDR,
  input  wire logic [sbcr_pkg::PDATA_W-1:0]  PWDATA,
  output logic      [sbcr_pkg::PDATA_W-1:0]  PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // Chip enables
  input  wire logic                          CHIP_SEL_A_N,
  input  wire logic                          CHIP_SEL_B,
  input  wire logic                          CHIP_SEL_C_N,
  // Strobes and advance
  input  wire logic                          PROC_ADDR_STROBE_N,
  input  wire logic                          CTRL_ADDR_STROBE_N,
  input  wire logic                          BURST_ADVANCE_N,
  // Write controls
  input  wire logic                          GLOBAL_WRITE_N,
  input  wire logic                          BYTE_WRITE_ENABLE_N,
  input  wire logic [sbcr_pkg::LANES-1:0]    BYTE_SELECT_N,
  // Address, order select, output enable, sleep
  input  wire logic [sbcr_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic                          BURST_ORDER,
  input  wire logic                          BURST_ORDER_DRIVEN,
  input  wire logic                          OUTPUT_ENABLE_N,
  input  wire logic                          SLEEP_REQUEST,
  // Data lines
  input  wire logic [sbcr_pkg::DATA_W-1:0]   DATA_I,
  output logic      [sbcr_pkg::DATA_W-1:0]   DATA_O,
  output logic                               DATA_OE,
  // Parity lines
  input  wire logic [sbcr_pkg::PAR_W-1:0]    PARITY_LINES_I,
  output logic      [sbcr_pkg::PAR_W-1:0]    PARITY_LINES_O,
  output logic                               PARITY_LINES_OE
);

  // ==========================================================
  // Declarations
  sbcr_pkg::sbcr_sleep_t                sleep_st_r;
  sbcr_pkg::sbcr_sleep_t                sleep_st_nxt;
  logic [1:0]                           sleep_cnt_r;
  logic                                 sleep_s1_r;
  logic                                 sleep_s2_r;
  logic                                 sleep_force_r;
  logic                                 sleep_req;
  logic                                 awake;
  logic                                 sel;
  logic                                 proc_strobe;
  logic                                 ctrl_strobe;
  logic                                 proc_go;
  logic                                 ctrl_go;
  logic                                 start;
  logic                                 desel;
  logic                                 cont;
  logic                                 step;
  logic                                 inter;
  logic [sbcr_pkg::LANES-1:0]           lanes;
  logic                                 wr_req;
  logic                                 wr_now;
  logic                                 mem_we;
  logic [sbcr_pkg::ADDR_W-1:0]          addr_use;
  logic [sbcr_pkg::ADDR_W-1:0]          addr_r;
  logic [sbcr_pkg::ADDR_W-3:0]          base_hi_r;
  logic [1:0]                           cnt_cur;
  logic [1:0]                           cnt_nxt;
  logic                                 active_r;
  logic                                 rd_valid_r;
  logic                                 rd_event;
  logic [sbcr_pkg::WORD_W-1:0]          wdata;
  logic [sbcr_pkg::WORD_W-1:0]          rdata;
  logic                                 drive;
  logic [sbcr_pkg::EV_CNT_W-1:0]        rd_cnt_r;
  logic [sbcr_pkg::EV_CNT_W-1:0]        wr_cnt_r;
  logic                                 apb_setup;
  logic                                 apb_wr;
  logic                                 cnt_clr;
  logic                                 mapped;
  logic [sbcr_pkg::PDATA_W-1:0]         rd_mux;

  // ==========================================================
  // Sleep request synchroniser
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= SLEEP_REQUEST;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  assign sleep_req = sleep_s2_r | sleep_force_r;

  // ==========================================================
  // Sleep sequencer: two cycles in, two cycles out
  always_comb begin
    sleep_st_nxt = sleep_st_r;
    case (sleep_st_r)
      sbcr_pkg::SBCR_AWAKE: begin
        if (sleep_req) begin
          sleep_st_nxt = sbcr_pkg::SBCR_ENTER; // [R19]
        end
      end
      sbcr_pkg::SBCR_ENTER: begin
        if (sleep_cnt_r == sbcr_pkg::SLEEP_LAST) begin
          sleep_st_nxt = sbcr_pkg::SBCR_SLEEP; // [R19]
        end
      end
      sbcr_pkg::SBCR_SLEEP: begin
        if (!sleep_req) begin
          sleep_st_nxt = sbcr_pkg::SBCR_EXIT; // [R19]
        end
      end
      sbcr_pkg::SBCR_EXIT: begin
        if (sleep_cnt_r == sbcr_pkg::SLEEP_LAST) begin
          sleep_st_nxt = sbcr_pkg::SBCR_AWAKE; // [R19]
        end
      end
      default: begin
        sleep_st_nxt = sbcr_pkg::SBCR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sleep_st_r <= sbcr_pkg::SBCR_AWAKE;
    end else begin
      sleep_st_r <= sleep_st_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || sleep_st_nxt != sleep_st_r) begin
      sleep_cnt_r <= 2'h0;
    end else if (sleep_st_r == sbcr_pkg::SBCR_ENTER ||
                 sleep_st_r == sbcr_pkg::SBCR_EXIT) begin
      sleep_cnt_r <= 2'(sleep_cnt_r + 2'h1);
    end
  end

  assign awake = (sleep_st_r == sbcr_pkg::SBCR_AWAKE);

  // ==========================================================
  // Cycle decode
  assign sel         = ~CHIP_SEL_A_N & CHIP_SEL_B & ~CHIP_SEL_C_N;
  // Processor strobe counts only with the first enable active
  assign proc_strobe = ~PROC_ADDR_STROBE_N & ~CHIP_SEL_A_N;
  assign ctrl_strobe = ~CTRL_ADDR_STROBE_N;
  assign proc_go     = awake & sel & proc_strobe; // [R2] [R9]
  assign ctrl_go     = awake & sel & ctrl_strobe & ~proc_strobe; // [R8] [R9]
  assign start       = proc_go | ctrl_go;
  assign desel       = ~sel & (proc_strobe | ctrl_strobe);
  assign cont        = awake & active_r & ~proc_strobe & ~ctrl_strobe;
  assign step        = cont & ~BURST_ADVANCE_N; // [R17] [R18]
  // Undriven order select reads as interleaved
  assign inter       = BURST_ORDER_DRIVEN ? BURST_ORDER : 1'b1; // [R13] [R14]

  // ==========================================================
  // Write detection and lane mask
  assign lanes  = sbcr_pkg::write_lanes(GLOBAL_WRITE_N, BYTE_WRITE_ENABLE_N,
                                        BYTE_SELECT_N); // [R4]
  assign wr_req = |lanes;
  // Processor-strobe start ignores write inputs; continuation honours them
  assign mem_we = (ctrl_go & wr_req) | (cont & wr_req); // [R3] [R7]
  assign wr_now = mem_we;
  assign rd_event = (proc_go) | (ctrl_go & ~wr_req) | (cont & ~wr_req); // [R9]

  // ==========================================================
  // Address path
  always_comb begin
    if (start) begin
      addr_use = ADDR; // [R2] [R7]
    end else if (step) begin
      addr_use = {base_hi_r, cnt_nxt}; // [R24] [R18]
    end else begin
      addr_use = {base_hi_r, cnt_cur}; // [R24] [R18]
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      base_hi_r <= '0;
    end else if (start) begin
      base_hi_r <= ADDR[sbcr_pkg::ADDR_W-1:2]; // [R24]
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      addr_r <= '0;
    end else if (start || cont) begin
      addr_r <= addr_use;
    end
  end

  sbcr_burst u_burst (
    .clk      (CLK),
    .reset    (RESET),
    .load     (start), // [R12]
    .load_val (ADDR[1:0]),
    .step     (step),
    .inter    (inter), // [R15] [R16]
    .cur      (cnt_cur),
    .nxt      (cnt_nxt)
  );

  // ==========================================================
  // Storage array
  assign wdata = {PARITY_LINES_I[1], DATA_I[15:8],
                  PARITY_LINES_I[0], DATA_I[7:0]}; // [R1] [R4]

  sbcr_mem u_mem (
    .clk     (CLK),
    .we      (mem_we), // [R20]
    .lane_en (lanes),
    .addr    (addr_use),
    .wdata   (wdata),
    .rdata   (rdata)
  );

  // ==========================================================
  // Access state; sleep drops any pending access
  always_ff @(posedge CLK) begin
    if (RESET || !awake) begin
      active_r <= 1'b0; // [R20]
    end else if (start) begin
      active_r <= 1'b1;
    end else if (desel) begin
      active_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || !awake) begin
      rd_valid_r <= 1'b0; // [R20]
    end else if (start || cont) begin
      rd_valid_r <= rd_event;
    end else if (desel) begin
      rd_valid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Data line drive
  assign drive = rd_valid_r & awake & ~wr_now & ~OUTPUT_ENABLE_N; // [R5] [R11] [R23]
  assign DATA_OE         = drive;
  assign PARITY_LINES_OE = drive;
  assign DATA_O          = {rdata[16:9], rdata[7:0]};
  assign PARITY_LINES_O  = {rdata[17], rdata[8]};

  // ==========================================================
  // Access counters
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_cnt_r <= '0;
    end else if (cnt_clr) begin
      rd_cnt_r <= {{(sbcr_pkg::EV_CNT_W-1){1'b0}}, rd_event};
    end else if (rd_event) begin
      rd_cnt_r <= rd_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_cnt_r <= '0;
    end else if (cnt_clr) begin
      wr_cnt_r <= {{(sbcr_pkg::EV_CNT_W-1){1'b0}}, mem_we};
    end else if (mem_we) begin
      wr_cnt_r <= wr_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // APB slave: zero wait, data registered in the setup cycle
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE;
  assign cnt_clr   = apb_wr & (PADDR == sbcr_pkg::REG_COUNT);
  assign PREADY    = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    case (PADDR)
      sbcr_pkg::REG_CTRL: begin
        rd_mux[sbcr_pkg::CTRL_SLEEP_BIT] = sleep_force_r;
      end
      sbcr_pkg::REG_STATUS: begin
        rd_mux[sbcr_pkg::ST_SLEEP_LSB +: 2] = sleep_st_r;
        rd_mux[sbcr_pkg::ST_ACTIVE_BIT]     = active_r;
        rd_mux[sbcr_pkg::ST_RDV_BIT]        = rd_valid_r;
        rd_mux[sbcr_pkg::ST_CNT_LSB +: 2]   = cnt_cur;
        rd_mux[sbcr_pkg::ST_ORDER_BIT]      = inter;
      end
      sbcr_pkg::REG_ADDR: begin
        rd_mux[sbcr_pkg::ADDR_W-1:0] = addr_r;
      end
      sbcr_pkg::REG_COUNT: begin
        rd_mux = {wr_cnt_r, rd_cnt_r};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (apb_setup) begin
      PRDATA  <= PWRITE ? '0 : rd_mux;
      PSLVERR <= ~mapped;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sleep_force_r <= sbcr_pkg::CTRL_SLEEP_RST;
    end else if (apb_wr && PADDR == sbcr_pkg::REG_CTRL) begin
      sleep_force_r <= PWDATA[sbcr_pkg::CTRL_SLEEP_BIT];
    end
  end

endmodule
`default_nettype wire

/* tb/sbcr_monitor.sv */
`default_nettype none
module sbcr_monitor (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Memory controls
  input wire logic        CHIP_SEL_A_N,
  input wire logic        CHIP_SEL_B,
  input wire logic        CHIP_SEL_C_N,
  input wire logic        PROC_ADDR_STROBE_N,
  input wire logic        CTRL_ADDR_STROBE_N,
  input wire logic        BURST_ADVANCE_N,
  input wire logic        GLOBAL_WRITE_N,
  input wire logic        BYTE_WRITE_ENABLE_N,
  input wire logic [1:0]  BYTE_SELECT_N,
  input wire logic        OUTPUT_ENABLE_N,
  input wire logic        SLEEP_REQUEST,
  // Data lines
  input wire logic [15:0] DATA_O,
  input wire logic        DATA_OE,
  input wire logic        PARITY_LINES_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // ==========================================================
  // Helpers
  logic       sel;
  logic       wr;
  logic       quiet;
  logic       awake;
  logic [3:0] awake_r;
  assign sel = !CHIP_SEL_A_N && CHIP_SEL_B && !CHIP_SEL_C_N;
  assign wr = !GLOBAL_WRITE_N || (!BYTE_WRITE_ENABLE_N && BYTE_SELECT_N != 2'b11);
  assign quiet = PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && !wr;
  assign awake = awake_r >= 4'h8;
  // Cycles since the sleep request was last high, saturating
  always_ff @(posedge CLK) begin
    if (RESET) begin
      awake_r <= 4'hf;
    end else if (SLEEP_REQUEST) begin
      awake_r <= 4'h0;
    end else if (awake_r != 4'hf) begin
      awake_r <= awake_r + 4'h1;
    end
  end
  // ==========================================================
  // Assertions
  chk_oe_gate: assert property (DATA_OE |-> !OUTPUT_ENABLE_N)
    else $error("data driven with output enable high");
  chk_lanes_paired: assert property (DATA_OE == PARITY_LINES_OE)
    else $error("parity drive differs from data drive");
  chk_write_release: assert property (wr && PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N |-> !DATA_OE)
    else $error("lines driven during a write");
  chk_sleep_quiet: assert property (SLEEP_REQUEST [*4] |-> !DATA_OE && !PARITY_LINES_OE)
    else $error("lines driven while asleep");
  chk_proc_read: assert property (awake && sel && !PROC_ADDR_STROBE_N
    ##1 quiet && !OUTPUT_ENABLE_N |-> DATA_OE)
    else $error("processor strobe read not driven");
  chk_ctrl_read: assert property (awake && sel && !CTRL_ADDR_STROBE_N && PROC_ADDR_STROBE_N && !wr
    ##1 quiet && !OUTPUT_ENABLE_N |-> DATA_OE)
    else $error("controller strobe read not driven");
  chk_suspend_hold: assert property (!$past(RESET) && quiet && BURST_ADVANCE_N
    ##1 quiet && BURST_ADVANCE_N |=> $stable(DATA_O))
    else $error("suspended burst changed data");
  chk_deselect_idle: assert property (!CHIP_SEL_A_N && (!CHIP_SEL_B || CHIP_SEL_C_N)
    && !PROC_ADDR_STROBE_N |=> !DATA_OE)
    else $error("deselect did not end access");
  cov_proc_read: cover property (sel && !PROC_ADDR_STROBE_N ##1 DATA_OE);
  cov_ctrl_write: cover property (sel && !CTRL_ADDR_STROBE_N && PROC_ADDR_STROBE_N && wr);
  cov_sleep: cover property (SLEEP_REQUEST [*4]);
endmodule
bind sbcr_top sbcr_monitor u_mon (.*);
`default_nettype wire

/* tb/sbcr_host_model.sv */
`default_nettype none
module sbcr_host_model (
  // Clock
  input  wire logic        clk,
  // Host request
  input  wire logic        drive_en,
  input  wire logic [17:0] drive_word,
  input  wire logic        oe_n,
  // Memory side
  input  wire logic [15:0] dq_o,
  input  wire logic [1:0]  dp_o,
  input  wire logic        dq_oe,
  // Resolved lines
  output logic      [15:0] dq_i,
  output logic      [1:0]  dp_i
);
  logic [17:0] last_r;
  logic [17:0] line;
  logic        host_on;
  // Host drives only after output enable is released and the memory is quiet
  assign host_on = drive_en && oe_n && !dq_oe;
  // Undriven lines show the inverse of the last level
  always_comb begin
    if (dq_oe) begin
      line = {dp_o[1], dq_o[15:8], dp_o[0], dq_o[7:0]};
    end else if (host_on) begin
      line = drive_word;
    end else begin
      line = ~last_r;
    end
  end
  always_ff @(posedge clk) begin
    last_r <= line;
  end
  assign dq_i = {line[16:9], line[7:0]};
  assign dp_i = {line[17], line[8]};
endmodule
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0]  ON = 3'b010;
  localparam logic [2:0]  OFF = 3'b101;
  localparam logic [1:0]  SP = 2'b01;
  localparam logic [1:0]  SC = 2'b10;
  localparam logic [1:0]  SN = 2'b11;
  localparam logic [3:0]  NW = 4'hf;
  localparam logic [16:0] BASE = 17'h12344;
  localparam logic [1:0]  ST [3] = '{2'h2, 2'h1, 2'h3};
  // ==========================================================
  // Signals
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, adv_n, oe_n;
  logic        hen, dq_oe, dp_oe, ord, ord_drv, slp, slp_v, e;
  logic [1:0]  st_v, mode_v, dp_i, dp_o, lo, j;
  logic [2:0]  ce_v;
  logic [3:0]  wr_v;
  logic [7:0]  paddr;
  logic [15:0] dq_i, dq_o;
  logic [16:0] addr;
  logic [17:0] hw, w;
  logic [17:0] mem [4];
  logic [31:0] pwdata, prdata, q;
  int          n_mismatch, compares, cycles;
  sbcr_top uut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CHIP_SEL_A_N(ce_v[2]), .CHIP_SEL_B(ce_v[1]), .CHIP_SEL_C_N(ce_v[0]),
    .PROC_ADDR_STROBE_N(st_v[1]), .CTRL_ADDR_STROBE_N(st_v[0]), .BURST_ADVANCE_N(adv_n),
    .GLOBAL_WRITE_N(wr_v[3]), .BYTE_WRITE_ENABLE_N(wr_v[2]), .BYTE_SELECT_N(wr_v[1:0]),
    .ADDR(addr), .BURST_ORDER(ord), .BURST_ORDER_DRIVEN(ord_drv), .OUTPUT_ENABLE_N(oe_n),
    .SLEEP_REQUEST(slp), .DATA_I(dq_i), .DATA_O(dq_o), .DATA_OE(dq_oe),
    .PARITY_LINES_I(dp_i), .PARITY_LINES_O(dp_o), .PARITY_LINES_OE(dp_oe));
  sbcr_host_model host (.clk(clk), .drive_en(hen), .drive_word(hw), .oe_n(oe_n),
    .dq_o(dq_o), .dp_o(dp_o), .dq_oe(dq_oe), .dq_i(dq_i), .dp_i(dp_i));
  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input logic [2:0] c, input logic [1:0] s, input logic v,
                     input logic [3:0] wv, input logic o, input logic [16:0] a,
                     input logic [17:0] d, input logic h);
    @(posedge clk);
    {ce_v, st_v, adv_n, wr_v, oe_n, addr, hw, hen, ord, ord_drv, slp} <=
      {c, s, v, wv, o, a, d, h, mode_v, slp_v};
  endtask
  task automatic rd(input logic [2:0] c, input logic [1:0] s, input logic v,
                    input logic o, input logic [16:0] a);
    cyc(c, s, v, NW, o, a, 18'h0, 1'b0);
  endtask
  task automatic look(input string what, input logic [18:0] exp);
    @(negedge clk);
    chk(what, 32'(exp), {13'h0, dq_oe, dp_o[1], dq_o[15:8], dp_o[0], dq_o[7:0]});
  endtask
  task automatic apb(input logic wrt, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wrt, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // ==========================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("MISMATCH timeout expected finish seen hang");
      stop_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, hen, hw, addr} = {4'h8, 76'h0};
    {ce_v, st_v, adv_n, wr_v, oe_n, ord, ord_drv, slp, slp_v} = {OFF, SN, 1'b0, NW, 5'h18};
    mode_v = 2'b11;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, sbcr_pkg::REG_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, q);
    apb(1'b1, sbcr_pkg::REG_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    apb(1'b0, sbcr_pkg::REG_STATUS, 32'h0);
    chk("forced_sleep", 32'h2, 32'(q[1:0]));
    apb(1'b1, sbcr_pkg::REG_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    apb(1'b0, sbcr_pkg::REG_STATUS, 32'h0);
    chk("awake_again", 32'h0, 32'(q[1:0]));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      mem[i] = 18'h2c3a5 ^ 18'(i * 32'h1357);
      cyc(ON, SC, 1'b0, 4'h7, 1'b1, BASE + 17'(i), mem[i], 1'b1);
    end
    w = ~mem[1];
    cyc(ON, 2'b00, 1'b1, 4'h7, 1'b1, BASE + 17'h1, w, 1'b1);
    cyc(ON, SN, 1'b1, 4'ha, 1'b1, BASE, w, 1'b1);
    mem[1][8:0] = w[8:0];
    rd(OFF, SN, 1'b0, 1'b1, BASE);
    apb(1'b0, sbcr_pkg::REG_COUNT, 32'h0);
    chk("write_count", 32'h5, 32'(q[31:16]));
    $display("test writes done");
    for (int m = 0; m < 3; m++) begin
      mode_v = {m != 0, m != 2};
      rd(ON, SP, 1'b0, 1'b0, {BASE[16:2], ST[m]});
      j = 2'h0;
      for (int k = 0; k < 7; k++) begin
        rd(ON, SN, k inside {1, 2}, k == 3, BASE);
        lo = (m != 0) ? (ST[m] ^ j) : (ST[m] + j);
        look("burst", {k != 3, mem[lo]});
        if (!(k inside {1, 2})) begin
          j = j + 2'h1;
        end
      end
    end
    $display("test bursts done");
    rd(ON, SC, 1'b0, 1'b0, BASE + 17'h2);
    rd(ON, SN, 1'b1, 1'b0, BASE);
    look("ctrl_read", {1'b1, mem[2]});
    rd(3'b000, SP, 1'b0, 1'b0, BASE);
    rd(OFF, SN, 1'b0, 1'b0, BASE);
    look("deselect", {1'b0, mem[2]});
    $display("test deselect done");
    rd(ON, SP, 1'b0, 1'b0, BASE);
    rd(OFF, SN, 1'b1, 1'b0, BASE);
    look("pre_sleep", {1'b1, mem[0]});
    slp_v = 1'b1;
    repeat (6) rd(OFF, SN, 1'b1, 1'b0, BASE);
    @(negedge clk);
    chk("sleep_oe", 32'h0, 32'(dq_oe));
    apb(1'b0, sbcr_pkg::REG_STATUS, 32'h0);
    chk("sleep_state", 32'h42, 32'(q[6:0]));
    slp_v = 1'b0;
    repeat (12) rd(OFF, SN, 1'b1, 1'b0, BASE);
    @(negedge clk);
    chk("dropped", 32'h0, 32'(dq_oe));
    rd(ON, SP, 1'b0, 1'b0, BASE + 17'h3);
    rd(OFF, SN, 1'b1, 1'b0, BASE);
    look("kept", {1'b1, mem[3]});
    $display("test sleep done");
    stop_test();
  end
endmodule
`default_nettype wire
